/* logic/imbg_mirror.sv */
// Function
// - With summing active the effective sensor size is the physical size divided by each factor, remainder dropped.
// - With summing active all area settings count summed columns and summed lines.
// - The area width counts virtual columns and is limited to the effective width.
// - The area height counts virtual lines and is limited to the effective height.
// - The selected flips are applied to each frame before it leaves toward the transmitter.
// - Horizontal mirroring sends each line's pixels in reversed order.
// - Vertical mirroring sends the lines of a frame in reversed order.
// - Both mirrors may be on together, reversing pixel and line order.
// - Horizontal mirroring leaves the measurement regions fixed to the physical sensor.
// - Vertical mirroring leaves the measurement regions fixed to the physical sensor.
// - Lines are mirrored in a frame whose first pixel is taken while the horizontal mirror control holds one.
// - Line order is reversed in a frame whose first pixel is taken while the vertical mirror control holds one.
// - Summing factors of two, three or four are accepted and one turns summing off.
`timescale 1ns/10ps
`default_nettype none
module imbg_mirror (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_horizontal_mirror_enable,
    input wire logic i_vertical_mirror_enable,
    input wire logic [imbg_pkg::FACTOR_W-1:0] i_column_sum_factor,
    input wire logic [imbg_pkg::FACTOR_W-1:0] i_line_sum_factor,
    input wire logic [imbg_pkg::CNT_W-1:0] i_aoi_width,
    input wire logic [imbg_pkg::CNT_W-1:0] i_aoi_height,
    input wire logic i_pix_valid,
    input wire logic i_pix_sof,
    input wire logic [imbg_pkg::PIX_W-1:0] i_pix_data,
    output logic o_pix_ready,
    output logic o_out_valid,
    output logic o_out_sof,
    output logic o_out_eol,
    output logic [imbg_pkg::PIX_W-1:0] o_out_data,
    input wire logic i_out_ready,
    output logic [imbg_pkg::CNT_W-1:0] o_effective_width,
    output logic [imbg_pkg::CNT_W-1:0] o_effective_height,
    output logic [imbg_pkg::CNT_W-1:0] o_aoi_width,
    output logic [imbg_pkg::CNT_W-1:0] o_aoi_height,
    output logic o_factor_invalid,
    output logic o_h_mirror_active,
    output logic o_v_mirror_active,
    output logic o_meas_valid,
    output logic [imbg_pkg::CNT_W-1:0] o_meas_col,
    output logic [imbg_pkg::CNT_W-1:0] o_meas_line
);
    localparam int CW = imbg_pkg::CNT_W;
    localparam int AW = imbg_pkg::ADDR_W;

    // divide a physical dimension by an accepted factor, dropping the remainder
    function automatic logic [CW-1:0] imbg_shrink(input logic [CW-1:0] dim,
                                                  input logic [imbg_pkg::FACTOR_W-1:0] f);
        logic [CW-1:0] r;
        r = dim;
        case (f)
            imbg_pkg::FACTOR_BY2: r = dim / CW'(imbg_pkg::FACTOR_BY2);
            imbg_pkg::FACTOR_BY3: r = dim / CW'(imbg_pkg::FACTOR_BY3);
            imbg_pkg::FACTOR_BY4: r = dim / CW'(imbg_pkg::FACTOR_BY4);
            default: r = dim;
        endcase
        return r;
    endfunction : imbg_shrink

    // clamp an area size to a limit and to the frame store, never zero
    function automatic logic [CW-1:0] imbg_clamp(input logic [CW-1:0] req,
                                                 input logic [CW-1:0] lim,
                                                 input logic [CW-1:0] cap);
        logic [CW-1:0] r;
        r = req;
        if (r > lim)
        begin
            r = lim;
        end
        if (r > cap)
        begin
            r = cap;
        end
        if (r == imbg_pkg::COUNT_RESET)
        begin
            r = imbg_pkg::COUNT_ONE;
        end
        return r;
    endfunction : imbg_clamp

    function automatic logic imbg_factor_ok(input logic [imbg_pkg::FACTOR_W-1:0] f);
        return (f >= imbg_pkg::FACTOR_OFF) && (f <= imbg_pkg::FACTOR_BY4);
    endfunction : imbg_factor_ok

    // geometry group
    logic [CW-1:0] eff_w_q, eff_w_d, eff_h_q, eff_h_d;
    logic [CW-1:0] aoi_w_q, aoi_w_d, aoi_h_q, aoi_h_d;
    logic fact_err_q, fact_err_d;

    // frame control group
    imbg_pkg::imbg_state_e state_q, state_d;
    logic hm_q, hm_d, vm_q, vm_d;
    logic [CW-1:0] cols_q, cols_d, lines_q, lines_d;
    logic [CW-1:0] col_q, col_d, line_q, line_d;
    logic [AW-1:0] wr_addr_q, wr_addr_d, base_q, base_d;
    logic rd_pend_q, rd_pend_d, rd_sof_q, rd_sof_d, rd_eol_q, rd_eol_d;
    logic ready_q, ready_d;
    logic meas_v_q, meas_v_d;
    logic [CW-1:0] meas_c_q, meas_c_d, meas_l_q, meas_l_d;

    // output stage group
    logic ov_q, ov_d, osof_q, osof_d, oeol_q, oeol_d;
    logic [imbg_pkg::PIX_W-1:0] odata_q, odata_d;

    logic [imbg_pkg::PIX_W-1:0] frame_q [imbg_pkg::FRAME_WORDS];
    logic [imbg_pkg::PIX_W-1:0] rd_data_q;

    logic cap_fire, last_col, last_line, issue;
    logic [CW-1:0] cap_cols, cap_lines, src_col;
    logic [AW-1:0] rd_addr;
    logic [2*CW-1:0] flip_base;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [imbg_pkg::FIFO_W-1:0] fifo_out_data;
    logic [imbg_pkg::FACTOR_W-1:0] col_f, line_f;

    // bad factors fall back to no summing and raise a flag
    always_comb
    begin
        col_f = imbg_factor_ok(i_column_sum_factor) ? i_column_sum_factor
                                                    : imbg_pkg::FACTOR_OFF;
        line_f = imbg_factor_ok(i_line_sum_factor) ? i_line_sum_factor
                                                   : imbg_pkg::FACTOR_OFF;
        fact_err_d = !imbg_factor_ok(i_column_sum_factor) || !imbg_factor_ok(i_line_sum_factor);
        eff_w_d = imbg_shrink(imbg_pkg::SENSOR_COLS, col_f);
        eff_h_d = imbg_shrink(imbg_pkg::SENSOR_LINES, line_f);
        // area counts are binned units, so the binned size is the limit
        aoi_w_d = imbg_clamp(i_aoi_width, eff_w_d, imbg_pkg::FRAME_MAX_COLS);
        aoi_h_d = imbg_clamp(i_aoi_height, eff_h_d, imbg_pkg::FRAME_MAX_LINES);
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            eff_w_q <= imbg_pkg::SENSOR_COLS;
            eff_h_q <= imbg_pkg::SENSOR_LINES;
            aoi_w_q <= imbg_pkg::COUNT_ONE;
            aoi_h_q <= imbg_pkg::COUNT_ONE;
            fact_err_q <= 1'b0;
        end
        else if (i_enable)
        begin
            eff_w_q <= eff_w_d;
            eff_h_q <= eff_h_d;
            aoi_w_q <= aoi_w_d;
            aoi_h_q <= aoi_h_d;
            fact_err_q <= fact_err_d;
        end
    end

    // a frame in progress keeps the sizes it started with
    assign cap_fire = i_enable && ready_q && i_pix_valid
                      && ((state_q == imbg_pkg::ST_CAPTURE) || i_pix_sof);
    assign cap_cols = (state_q == imbg_pkg::ST_IDLE) ? aoi_w_q : cols_q;
    assign cap_lines = (state_q == imbg_pkg::ST_IDLE) ? aoi_h_q : lines_q;
    assign last_col = (col_q == cap_cols - imbg_pkg::COUNT_ONE);
    assign last_line = (line_q == cap_lines - imbg_pkg::COUNT_ONE);
    // one read in flight at a time: half rate, but the fifo can never overflow
    assign issue = i_enable && (state_q == imbg_pkg::ST_PLAY) && fifo_in_ready && !rd_pend_q;
    assign src_col = hm_q ? (cols_q - imbg_pkg::COUNT_ONE - col_q) : col_q;
    assign rd_addr = base_q + AW'(src_col);
    // built from the capture sizes, not the next-state values, to keep the comb path acyclic
    assign flip_base = (cap_lines - imbg_pkg::COUNT_ONE) * cap_cols;

    // capture the frame in sensor order, then play it out in mirrored order
    always_comb
    begin
        state_d = state_q;
        hm_d = hm_q;
        vm_d = vm_q;
        cols_d = cols_q;
        lines_d = lines_q;
        col_d = col_q;
        line_d = line_q;
        wr_addr_d = wr_addr_q;
        base_d = base_q;
        rd_pend_d = issue;
        rd_sof_d = issue && (col_q == imbg_pkg::COUNT_RESET) && (line_q == imbg_pkg::COUNT_RESET);
        rd_eol_d = issue && (col_q == cols_q - imbg_pkg::COUNT_ONE);
        meas_v_d = cap_fire;
        // measurement tap sees sensor order, unaffected by any flip
        meas_c_d = cap_fire ? col_q : meas_c_q;
        meas_l_d = cap_fire ? line_q : meas_l_q;
        case (state_q)
            imbg_pkg::ST_IDLE, imbg_pkg::ST_CAPTURE:
            begin
                if (cap_fire)
                begin
                    if (state_q == imbg_pkg::ST_IDLE)
                    begin
                        hm_d = i_horizontal_mirror_enable;
                        vm_d = i_vertical_mirror_enable;
                        cols_d = aoi_w_q;
                        lines_d = aoi_h_q;
                        state_d = imbg_pkg::ST_CAPTURE;
                    end
                    wr_addr_d = wr_addr_q + imbg_pkg::ADDR_ONE;
                    if (!last_col)
                    begin
                        col_d = col_q + imbg_pkg::COUNT_ONE;
                    end
                    else
                    begin
                        col_d = imbg_pkg::COUNT_RESET;
                        line_d = line_q + imbg_pkg::COUNT_ONE;
                        if (last_line)
                        begin
                            // frame stored: start at bottom line when flipping
                            line_d = imbg_pkg::COUNT_RESET;
                            base_d = vm_d ? flip_base[AW-1:0] : imbg_pkg::ADDR_RESET;
                            state_d = imbg_pkg::ST_PLAY;
                        end
                    end
                end
            end
            imbg_pkg::ST_PLAY:
            begin
                if (issue)
                begin
                    if (col_q != cols_q - imbg_pkg::COUNT_ONE)
                    begin
                        col_d = col_q + imbg_pkg::COUNT_ONE;
                    end
                    else
                    begin
                        col_d = imbg_pkg::COUNT_RESET;
                        line_d = line_q + imbg_pkg::COUNT_ONE;
                        // both flips combine freely: line step and pixel index are independent
                        base_d = vm_q ? base_q - AW'(cols_q) : base_q + AW'(cols_q);
                        if (line_q == lines_q - imbg_pkg::COUNT_ONE)
                        begin
                            line_d = imbg_pkg::COUNT_RESET;
                            wr_addr_d = imbg_pkg::ADDR_RESET;
                            state_d = imbg_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                state_d = imbg_pkg::ST_IDLE;
            end
        endcase
        // the source is held off while the store is being played out
        ready_d = (state_d != imbg_pkg::ST_PLAY);
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            state_q <= imbg_pkg::ST_IDLE;
            hm_q <= imbg_pkg::MIRROR_RESET;
            vm_q <= imbg_pkg::MIRROR_RESET;
            cols_q <= imbg_pkg::COUNT_ONE;
            lines_q <= imbg_pkg::COUNT_ONE;
            col_q <= imbg_pkg::COUNT_RESET;
            line_q <= imbg_pkg::COUNT_RESET;
            wr_addr_q <= imbg_pkg::ADDR_RESET;
            base_q <= imbg_pkg::ADDR_RESET;
            rd_pend_q <= 1'b0;
            rd_sof_q <= 1'b0;
            rd_eol_q <= 1'b0;
            ready_q <= 1'b0;
            meas_v_q <= 1'b0;
            meas_c_q <= imbg_pkg::COUNT_RESET;
            meas_l_q <= imbg_pkg::COUNT_RESET;
        end
        else if (i_enable)
        begin
            state_q <= state_d;
            hm_q <= hm_d;
            vm_q <= vm_d;
            cols_q <= cols_d;
            lines_q <= lines_d;
            col_q <= col_d;
            line_q <= line_d;
            wr_addr_q <= wr_addr_d;
            base_q <= base_d;
            rd_pend_q <= rd_pend_d;
            rd_sof_q <= rd_sof_d;
            rd_eol_q <= rd_eol_d;
            ready_q <= ready_d;
            meas_v_q <= meas_v_d;
            meas_c_q <= meas_c_d;
            meas_l_q <= meas_l_d;
        end
    end

    // frame store: written in sensor order, read in mirrored order
    always_ff @(posedge i_clock)
    begin
        if (cap_fire)
        begin
            frame_q[wr_addr_q] <= i_pix_data;
        end
        if (issue)
        begin
            rd_data_q <= frame_q[rd_addr];
        end
    end

    imbg_fifo #(
        .WIDTH(imbg_pkg::FIFO_W),
        .DEPTH(imbg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_enable(i_enable),
        .i_in_valid(rd_pend_q),
        .i_in_data({rd_sof_q, rd_eol_q, rd_data_q}),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(fifo_out_ready)
    );

    // output register refills whenever empty or being taken
    assign fifo_out_ready = !ov_q || i_out_ready;

    always_comb
    begin
        ov_d = ov_q;
        osof_d = osof_q;
        oeol_d = oeol_q;
        odata_d = odata_q;
        if (fifo_out_ready)
        begin
            ov_d = fifo_out_valid;
            osof_d = fifo_out_data[imbg_pkg::FIFO_W-1];
            oeol_d = fifo_out_data[imbg_pkg::PIX_W];
            odata_d = fifo_out_data[imbg_pkg::PIX_W-1:0];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            ov_q <= 1'b0;
            osof_q <= 1'b0;
            oeol_q <= 1'b0;
            odata_q <= imbg_pkg::PIX_RESET;
        end
        else if (i_enable)
        begin
            ov_q <= ov_d;
            osof_q <= osof_d;
            oeol_q <= oeol_d;
            odata_q <= odata_d;
        end
    end

    assign o_pix_ready = ready_q;
    assign o_out_valid = ov_q;
    assign o_out_sof = osof_q;
    assign o_out_eol = oeol_q;
    assign o_out_data = odata_q;
    assign o_effective_width = eff_w_q;
    assign o_effective_height = eff_h_q;
    assign o_aoi_width = aoi_w_q;
    assign o_aoi_height = aoi_h_q;
    assign o_factor_invalid = fact_err_q;
    assign o_h_mirror_active = hm_q;
    assign o_v_mirror_active = vm_q;
    assign o_meas_valid = meas_v_q;
    assign o_meas_col = meas_c_q;
    assign o_meas_line = meas_l_q;
endmodule : imbg_mirror
`default_nettype wire

/* logic/imbg_pkg.sv */
`default_nettype none
package imbg_pkg;
    // pixel and counter widths
    localparam int PIX_W = 12;
    localparam int CNT_W = 12;
    localparam int FACTOR_W = 3;
    localparam int FIFO_W = PIX_W + 2;
    localparam int FIFO_DEPTH = 8;
    // physical sensor size in unbinned columns and lines
    localparam logic [CNT_W-1:0] SENSOR_COLS = 12'h800;
    localparam logic [CNT_W-1:0] SENSOR_LINES = 12'h440;
    // frame store capacity, in binned columns and lines
    localparam logic [CNT_W-1:0] FRAME_MAX_COLS = 12'h040;
    localparam logic [CNT_W-1:0] FRAME_MAX_LINES = 12'h040;
    localparam int FRAME_WORDS = 4096;
    localparam int ADDR_W = 12;
    // summing factors: one means off, two to four sum that many
    localparam logic [FACTOR_W-1:0] FACTOR_OFF = 3'h1;
    localparam logic [FACTOR_W-1:0] FACTOR_BY2 = 3'h2;
    localparam logic [FACTOR_W-1:0] FACTOR_BY3 = 3'h3;
    localparam logic [FACTOR_W-1:0] FACTOR_BY4 = 3'h4;
    // reset values
    localparam logic MIRROR_RESET = 1'b0;
    localparam logic [CNT_W-1:0] COUNT_RESET = 12'h000;
    localparam logic [CNT_W-1:0] COUNT_ONE = 12'h001;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
    localparam logic [PIX_W-1:0] PIX_RESET = 12'h000;

    typedef enum logic [1:0] {ST_IDLE, ST_CAPTURE, ST_PLAY} imbg_state_e;
endpackage : imbg_pkg
`default_nettype wire

/* logic/imbg_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module imbg_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_C = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PTR_W:0] cnt_q, cnt_d;
    logic push, pop;

    // full and empty come straight from the occupancy count
    assign o_in_ready = (cnt_q != DEPTH_C);
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];
    assign push = i_enable && i_in_valid && o_in_ready;
    assign pop = i_enable && i_out_ready && o_out_valid;

    // pointer wrap and count update
    always_comb
    begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            wr_d = (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset, only the pointers matter
    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_in_data;
        end
    end
endmodule : imbg_fifo
`default_nettype wire

/* testbench/imbg_mirror_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module imbg_mirror_checker (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic [2:0] i_column_sum_factor,
    input wire logic [2:0] i_line_sum_factor,
    input wire logic [11:0] i_aoi_width,
    input wire logic i_pix_valid,
    input wire logic i_pix_sof,
    input wire logic o_pix_ready,
    input wire logic o_out_valid,
    input wire logic o_out_sof,
    input wire logic [11:0] o_out_data,
    input wire logic i_out_ready,
    input wire logic [11:0] o_effective_width,
    input wire logic [11:0] o_effective_height,
    input wire logic [11:0] o_aoi_width,
    input wire logic o_factor_invalid,
    input wire logic o_h_mirror_active,
    input wire logic o_v_mirror_active,
    input wire logic o_meas_valid,
    input wire logic [11:0] o_meas_col,
    input wire logic [11:0] o_meas_line
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    // out-of-range factors count as no summing
    function automatic logic [11:0] fx(input logic [2:0] v);
        return (v >= 3'h1 && v <= 3'h4) ? {9'h000, v} : 12'h001;
    endfunction : fx

    // width clamp: never above the store, never zero
    function automatic logic [11:0] lim(input logic [11:0] r, input logic [11:0] e);
        logic [11:0] m;
        m = (r < e) ? r : e;
        m = (m < 12'h040) ? m : 12'h040;
        return (m == 12'h000) ? 12'h001 : m;
    endfunction : lim

    property p_eff_w;
        i_enable |=> o_effective_width == imbg_pkg::SENSOR_COLS / fx($past(i_column_sum_factor));
    endproperty
    a_eff_w: assert property (p_eff_w) else $error("effective width wrong");
    property p_eff_h;
        i_enable |=> o_effective_height == imbg_pkg::SENSOR_LINES / fx($past(i_line_sum_factor));
    endproperty
    a_eff_h: assert property (p_eff_h) else $error("effective height wrong");
    // reset is sampled in the antecedent so the release edge still holds the reset value
    property p_aoi_w;
        i_enable && !i_reset |=> o_aoi_width ==
            lim($past(i_aoi_width), imbg_pkg::SENSOR_COLS / fx($past(i_column_sum_factor)));
    endproperty
    a_aoi_w: assert property (p_aoi_w) else $error("area width clamp wrong");
    property p_flag;
        i_enable |=> o_factor_invalid == ($past(i_column_sum_factor) > 3'h4 ||
            $past(i_column_sum_factor) == 3'h0 || $past(i_line_sum_factor) > 3'h4 ||
            $past(i_line_sum_factor) == 3'h0);
    endproperty
    a_flag: assert property (p_flag) else $error("factor flag wrong");
    // first taken beat sits at the sensor origin whatever the mirrors say
    property p_meas_first;
        i_enable && o_pix_ready && i_pix_valid && i_pix_sof |=>
            o_meas_valid && o_meas_col == 12'h000 && o_meas_line == 12'h000;
    endproperty
    a_meas_first: assert property (p_meas_first) else $error("tap origin wrong");
    property p_meas_none;
        !(i_enable && o_pix_ready && i_pix_valid) |=> !o_meas_valid;
    endproperty
    a_meas_none: assert property (p_meas_none) else $error("tap pulse unprompted");
    property p_out_hold;
        o_out_valid && !(i_out_ready && i_enable) |=>
            o_out_valid && $stable(o_out_data) && $stable(o_out_sof);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output dropped in stall");
    property p_mirror_hold;
        !o_pix_ready && !$past(o_pix_ready) |->
            $stable(o_h_mirror_active) && $stable(o_v_mirror_active);
    endproperty
    a_mirror_hold: assert property (p_mirror_hold) else $error("mirror moved");

    c_both: cover property (o_out_valid && o_out_sof && o_h_mirror_active && o_v_mirror_active);
    c_bad: cover property (o_factor_invalid);
    c_stall: cover property (o_out_valid && !i_out_ready [*3]);
endmodule : imbg_mirror_checker

bind imbg_mirror imbg_mirror_checker u_chk (.i_clock(i_clock), .i_reset(i_reset),
    .i_enable(i_enable), .i_column_sum_factor(i_column_sum_factor),
    .i_line_sum_factor(i_line_sum_factor), .i_aoi_width(i_aoi_width),
    .i_pix_valid(i_pix_valid), .i_pix_sof(i_pix_sof), .o_pix_ready(o_pix_ready),
    .o_out_valid(o_out_valid), .o_out_sof(o_out_sof), .o_out_data(o_out_data),
    .i_out_ready(i_out_ready), .o_effective_width(o_effective_width),
    .o_effective_height(o_effective_height), .o_aoi_width(o_aoi_width),
    .o_factor_invalid(o_factor_invalid), .o_h_mirror_active(o_h_mirror_active),
    .o_v_mirror_active(o_v_mirror_active), .o_meas_valid(o_meas_valid),
    .o_meas_col(o_meas_col), .o_meas_line(o_meas_line));
`default_nettype wire

/* testbench/imbg_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
module imbg_far_end (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_hold,
    input wire logic i_valid,
    input wire logic i_sof,
    input wire logic i_eol,
    input wire logic [11:0] i_data,
    output logic o_ready
);
    logic [1:0] pace_q;
    logic [13:0] got[$];

    // transmitter busy one cycle in three, and fully stalled while held
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            pace_q <= 2'h0;
            o_ready <= 1'b0;
        end
        else
        begin
            pace_q <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
            o_ready <= !i_hold && (pace_q != 2'h1);
            if (i_valid && o_ready)
                got.push_back({i_sof, i_eol, i_data});
        end
    end
endmodule : imbg_far_end
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic h_en = 1'b0, v_en = 1'b0, pv = 1'b0, psof = 1'b0, hold = 1'b0;
    logic [2:0] col_f = 3'h1, line_f = 3'h1;
    logic [11:0] aoi_w = 12'h005, aoi_h = 12'h003, pdata = 12'h000;
    logic pready, ov, osof, oeol, ordy, finv, mv;
    logic [11:0] odata, ew, eh, aw, ah;
    int fail_count = 0, checked = 0, cycles = 0, meas_n = 0;

    imbg_mirror u_imbg_mirror (.i_clock(i_clock), .i_reset(i_reset), .i_enable(1'b1),
        .i_horizontal_mirror_enable(h_en), .i_vertical_mirror_enable(v_en),
        .i_column_sum_factor(col_f), .i_line_sum_factor(line_f), .i_aoi_width(aoi_w),
        .i_aoi_height(aoi_h), .i_pix_valid(pv), .i_pix_sof(psof), .i_pix_data(pdata),
        .o_pix_ready(pready), .o_out_valid(ov), .o_out_sof(osof), .o_out_eol(oeol),
        .o_out_data(odata), .i_out_ready(ordy), .o_effective_width(ew),
        .o_effective_height(eh), .o_aoi_width(aw), .o_aoi_height(ah),
        .o_factor_invalid(finv), .o_h_mirror_active(), .o_v_mirror_active(),
        .o_meas_valid(mv), .o_meas_col(), .o_meas_line());
    imbg_far_end u_far_end (.i_clock(i_clock), .i_reset(i_reset), .i_hold(hold),
        .i_valid(ov), .i_sof(osof), .i_eol(oeol), .i_data(odata), .o_ready(ordy));

    always #50 i_clock = ~i_clock;

    // hang guard plus count of tap pulses
    always @(posedge i_clock)
    begin
        cycles++;
        if (mv === 1'b1)
            meas_n++;
        if (cycles == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    function automatic logic [11:0] ef(input int v);
        return (v >= 1 && v <= 4) ? 12'(v) : 12'h001;
    endfunction : ef

    // 5x3 raster; enables flipped once sof is taken to show they are latched
    task automatic send_frame(input logic h, input logic v);
        h_en <= h;
        v_en <= v;
        for (int r = 0; r < 3; r++)
            for (int c = 0; c < 5; c++)
            begin
                pv <= 1'b1;
                psof <= (r == 0 && c == 0);
                pdata <= {r[5:0], c[5:0]};
                @(posedge i_clock);
                while (pready !== 1'b1)
                    @(posedge i_clock);
                h_en <= ~h;
                v_en <= ~v;
            end
        pv <= 1'b0;
        psof <= 1'b0;
        pdata <= ~pdata; // released source shows no stale pixel
    endtask : send_frame

    task automatic check_frame(input logic h, input logic v, input int base);
        int rr, cc;
        while (u_far_end.got.size() < 15)
            @(posedge i_clock);
        check(14'(meas_n - base), 14'h000f);
        for (int r = 0; r < 3; r++)
            for (int c = 0; c < 5; c++)
            begin
                rr = v ? 2 - r : r;
                cc = h ? 4 - c : c;
                check(u_far_end.got.pop_front(),
                    {r == 0 && c == 0, c == 4, rr[5:0], cc[5:0]});
            end
    endtask : check_frame

    // main sequence: reset values, geometry table, then four frames, one per mirror setting
    initial
    begin
        int base;
        repeat (12) @(posedge i_clock);
        check({2'h0, ew}, {2'h0, imbg_pkg::SENSOR_COLS});
        check({2'h0, eh}, {2'h0, imbg_pkg::SENSOR_LINES});
        check({pready, ov, aw}, 14'h0001);
        i_reset <= 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            col_f <= k[2:0];
            line_f <= 3'(5 - k);
            aoi_w <= 12'h03e + k[11:0];
            aoi_h <= k[11:0];
            repeat (2) @(posedge i_clock);
            check({2'h0, ew}, {2'h0, imbg_pkg::SENSOR_COLS / ef(k)});
            check({2'h0, eh}, {2'h0, imbg_pkg::SENSOR_LINES / ef(5 - k)});
            check({2'h0, aw}, (k < 2) ? 14'h003e + 14'(k) : 14'h0040);
            check({2'h0, ah}, (k == 0) ? 14'h0001 : 14'(k));
            check({13'h0000, finv}, {13'h0000, k == 0 || k == 5});
        end
        col_f <= 3'h2;
        line_f <= 3'h2;
        aoi_w <= 12'h005;
        aoi_h <= 12'h003;
        @(posedge i_clock);
        for (int m = 0; m < 4; m++)
        begin
            hold <= (m == 3);
            base = meas_n;
            send_frame(m[0], m[1]);
            if (m == 3)
            begin
                repeat (40) @(posedge i_clock);
                hold <= 1'b0;
            end
            check_frame(m[0], m[1], base);
        end
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
